// >>> verilog/ebps_sequencer.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// external bus phase sequencer, one bus cycle at a time
module ebps_sequencer #(
   parameter logic [ebps_pkg::PRE_W-1:0] TU_DIV = ebps_pkg::TU_DIV_DEF
) (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire logic                        ce,
   input  wire logic                        linkClk,
   input  wire logic [3:0]                  regAddr,
   input  wire logic [ebps_pkg::DATA_W-1:0] regWdata,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic      [ebps_pkg::DATA_W-1:0] regRdata,
   input  wire logic                        readyPin,
   output ebps_pkg::ebps_bus_t              busOut
);
   localparam logic [ebps_pkg::PRE_W-1:0] TU_M1 = TU_DIV - 8'h01;  // strobes move only on unit edges
   localparam int CTRL_W = $bits(ebps_pkg::ebps_ctrl_t);
   localparam int TCFG_W = $bits(ebps_pkg::ebps_tcfg_t);
   localparam int STAT_W = $bits(ebps_pkg::ebps_stat_t);
   localparam logic [1:0] OFS_TCFG_HI = ebps_pkg::OFS_TCFG[3:ebps_pkg::CS_W];  // slot group of timing words
   localparam bit SYS_OK = (ebps_pkg::SYS_MHZ <= ebps_pkg::MAX_SYS_MHZ);        // clock slow enough on its own

   // whole block state in one record
   typedef struct packed {
      ebps_pkg::ebps_phase_t                       phase;
      logic [ebps_pkg::PRE_W-1:0]                  pre;      // time unit prescaler
      logic [ebps_pkg::CNT_W-1:0]                  cnt;      // units left minus one
      ebps_pkg::ebps_tcfg_t                        cfg;      // snapshot for this cycle
      logic [ebps_pkg::CS_W-1:0]                   cs;
      logic [ebps_pkg::CS_W-1:0]                   lastCs;   // window of last cycle
      logic                                        lastVal;
      logic                                        extOn;    // window changed
      logic                                        wr;
      logic                                        waitSeen; // one ready wait done
      logic [ebps_pkg::WAIT_W-1:0]                 waitCnt;
      logic                                        done;
      ebps_pkg::ebps_tcfg_t [ebps_pkg::N_CS-1:0]   tcfg;
      ebps_pkg::ebps_bus_t                         bus;
      logic [ebps_pkg::DATA_W-1:0]                 rdata;
   } ebps_st_t;

   ebps_st_t                    s;        // registered state
   ebps_st_t                    n;        // next state
   logic                        tick;     // end of one time unit
   logic                        linkRdy;  // ready seen on link clock
   logic [1:0]                  rdySync;  // [1] link path, [0] async path
   logic                        rdyLvl;   // ready level for this cycle
   logic                        rdyAct;   // ready after polarity
   logic                        advance;  // leave current phase
   ebps_pkg::ebps_phase_t       goPh;     // phase to enter
   ebps_pkg::ebps_ctrl_t        wrCtrl;   // write data as control word
   ebps_pkg::ebps_stat_t        stat;     // status view
   logic [ebps_pkg::CS_W-1:0]   tIdx;     // timing slot addressed
   logic                        tHit;     // address lands on a slot

   // skip phases programmed to zero length
   function automatic ebps_pkg::ebps_phase_t skipTo(
      input ebps_pkg::ebps_phase_t ph,
      input ebps_pkg::ebps_tcfg_t  c
   );
      ebps_pkg::ebps_phase_t p;
      p = ph;
      if (p == ebps_pkg::ST_C && c.c == 2'h0) begin
         p = ebps_pkg::ST_D;
      end
      if (p == ebps_pkg::ST_D && !c.d) begin
         p = ebps_pkg::ST_E;
      end
      if (p == ebps_pkg::ST_F && c.f == 2'h0) begin
         p = ebps_pkg::ST_IDLE;
      end
      return p;
   endfunction

   // units minus one, loaded at phase entry
   function automatic logic [ebps_pkg::CNT_W-1:0] loadCnt(
      input ebps_pkg::ebps_phase_t ph,
      input ebps_pkg::ebps_tcfg_t  c,
      input logic                  ext
   );
      logic [ebps_pkg::CNT_W-1:0] v;
      v = '0;
      unique case (ph)
         ebps_pkg::ST_AB: begin
            v = {4'h0, c.ab} + (ext ? {3'h0, c.abExt} : 5'h00);
         end
         ebps_pkg::ST_C: begin
            v = {3'h0, c.c - 2'h1};
         end
         ebps_pkg::ST_E: begin
            v = c.e;
         end
         ebps_pkg::ST_F: begin
            v = {3'h0, c.f - 2'h1};
         end
         ebps_pkg::ST_IDLE, ebps_pkg::ST_D, ebps_pkg::ST_RDY: begin
            v = '0;
         end
         default: begin
            v = '0;
         end
      endcase
      return v;
   endfunction

   // ready pin seen on the link clock
   ebps_link_ready u_link (
      .linkClk  (linkClk),
      .reset    (reset),
      .readyPin (readyPin),
      .linkRdy  (linkRdy)
   );

   // both ready paths cross into the system domain
   ebps_sync2 #(
      .W (2)
   ) u_sync (
      .clk   (clk),
      .reset (reset),
      .ce    (ce),
      .d     ({linkRdy, readyPin}),
      .q     (rdySync)
   );

   // ready select and polarity
   assign rdyLvl = s.cfg.rdyAsync ? rdySync[0] : rdySync[1];
   assign rdyAct = (rdyLvl == s.cfg.rdyPol);

   // a tick closes each time unit of a running cycle
   assign tick   = (s.phase != ebps_pkg::ST_IDLE) && (s.pre == TU_M1);

   // register port decode helpers
   assign wrCtrl = ebps_pkg::ebps_ctrl_t'(regWdata[CTRL_W-1:0]);
   assign tIdx   = regAddr[ebps_pkg::CS_W-1:0];
   assign tHit   = (regAddr[3:ebps_pkg::CS_W] == OFS_TCFG_HI);

   // status view
   always_comb begin
      stat.done    = s.done;
      stat.busy    = s.bus.busy;
      stat.phase   = s.phase;
      stat.waitCnt = s.waitCnt;
   end

   // phase exit decision and the phase that follows
   always_comb begin
      advance = 1'b0;
      goPh    = s.phase;
      if (tick && s.cnt == '0) begin
         advance = 1'b1;
         unique case (s.phase)
            ebps_pkg::ST_AB: begin
               goPh = skipTo(ebps_pkg::ST_C, s.cfg);
            end
            ebps_pkg::ST_C: begin
               goPh = skipTo(ebps_pkg::ST_D, s.cfg);
            end
            ebps_pkg::ST_D: begin
               goPh = ebps_pkg::ST_E;
            end
            ebps_pkg::ST_E: begin
               // mandatory access units done, then ready may govern
               goPh = s.cfg.rdyEn ? ebps_pkg::ST_RDY
                                  : skipTo(ebps_pkg::ST_F, s.cfg);
            end
            ebps_pkg::ST_RDY: begin
               // async needs one wait before its sample counts
               if (rdyAct && (s.waitSeen || !s.cfg.rdyAsync)) begin
                  goPh = skipTo(ebps_pkg::ST_F, s.cfg);
               end else begin
                  advance = 1'b0;
               end
            end
            ebps_pkg::ST_F: begin
               goPh = ebps_pkg::ST_IDLE;
            end
            ebps_pkg::ST_IDLE: begin
               advance = 1'b0;
            end
            default: begin
               goPh = ebps_pkg::ST_IDLE;  // illegal code recovers
            end
         endcase
      end
   end

   // next state
   always_comb begin
      n       = s;
      n.rdata = '0;  // read data stand for one cycle only

      // prescaler runs only inside a cycle
      if (s.phase != ebps_pkg::ST_IDLE) begin
         n.pre = tick ? '0 : s.pre + 8'h01;
      end

      // counting down the current phase
      if (tick && s.cnt != '0) begin
         n.cnt = s.cnt - 5'h01;
      end

      // ready waitstate bookkeeping
      if (tick && s.phase == ebps_pkg::ST_RDY && !advance) begin
         n.waitSeen = 1'b1;
         if (s.waitCnt != '1) begin
            n.waitCnt = s.waitCnt + 8'h01;
         end
      end

      // phase change loads the new counter
      if (advance) begin
         n.phase = goPh;
         n.cnt   = loadCnt(goPh, s.cfg, s.extOn);
      end

      // register writes
      if (regWr) begin
         if (regAddr == ebps_pkg::OFS_CTRL) begin
            n.bus.refClkSel = wrCtrl.clkSel;
            // start is ignored while a cycle runs
            if (wrCtrl.start && s.phase == ebps_pkg::ST_IDLE) begin
               n.phase    = ebps_pkg::ST_AB;
               n.pre      = '0;
               n.cfg      = s.tcfg[wrCtrl.cs];
               n.cs       = wrCtrl.cs;
               n.wr       = wrCtrl.wr;
               n.extOn    = !s.lastVal || (s.lastCs != wrCtrl.cs);
               n.cnt      = loadCnt(ebps_pkg::ST_AB, s.tcfg[wrCtrl.cs], n.extOn);
               n.waitSeen = 1'b0;
               n.waitCnt  = '0;
            end
         end else if (regAddr == ebps_pkg::OFS_STAT) begin
            if (regWdata[STAT_W-1]) begin
               n.done = 1'b0;  // write one clears
            end
         end else if (tHit) begin
            n.tcfg[tIdx] = ebps_pkg::ebps_tcfg_t'(regWdata[TCFG_W-1:0]);
         end
      end

      // cycle end sets done; the set wins over a clear
      if (advance && goPh == ebps_pkg::ST_IDLE) begin
         n.done    = 1'b1;
         n.lastCs  = s.cs;
         n.lastVal = 1'b1;
      end

      // register reads, answered next cycle
      if (regRd) begin
         if (regAddr == ebps_pkg::OFS_CTRL) begin
            n.rdata = {{(ebps_pkg::DATA_W-CTRL_W){1'b0}},
                       s.bus.refClkSel, s.cs, s.wr, 1'b0};
         end else if (regAddr == ebps_pkg::OFS_STAT) begin
            n.rdata = {{(ebps_pkg::DATA_W-STAT_W){1'b0}}, stat};
         end else if (tHit) begin
            n.rdata = s.tcfg[tIdx];
         end
      end

      // bus strobes follow the next phase
      for (int i = 0; i < ebps_pkg::N_CS; i++) begin
         n.bus.csSel[i] = (n.phase != ebps_pkg::ST_IDLE) && (n.cs == i[ebps_pkg::CS_W-1:0]);
      end
      n.bus.ale    = (n.phase == ebps_pkg::ST_AB);
      n.bus.cmdRd  = !n.wr && (n.phase == ebps_pkg::ST_E || n.phase == ebps_pkg::ST_RDY);
      n.bus.cmdWr  = n.wr && (n.phase == ebps_pkg::ST_E || n.phase == ebps_pkg::ST_RDY);
      n.bus.dataOe = n.wr && (n.phase >= ebps_pkg::ST_D) && (n.phase != ebps_pkg::ST_IDLE);
      n.bus.busy   = (n.phase != ebps_pkg::ST_IDLE);
   end

   // state register, frozen while ce is low
   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   // outputs straight from the state flops
   assign busOut   = s.bus;
   assign regRdata = s.rdata;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset || !ce);

   phase_order_a: assert property (
      $changed(s.phase) |-> (s.phase > $past(s.phase)) || (s.phase == ebps_pkg::ST_IDLE))
      else $error("phase order broken");
   cmd_len_a: assert property (
      $rose(s.phase == ebps_pkg::ST_C) |-> (s.cnt + 1 == s.cfg.c))
      else $error("command delay length wrong");
   ab_len_a: assert property (
      $rose(s.phase == ebps_pkg::ST_AB) |-> (s.cnt == s.cfg.ab + (s.extOn ? s.cfg.abExt : 0)))
      else $error("address setup length wrong");
   d_skip_a: assert property (
      $rose(s.phase == ebps_pkg::ST_D) |-> s.cfg.d && (s.cnt == '0))
      else $error("write setup phase entered with zero length");
   hold_len_a: assert property (
      $rose(s.phase == ebps_pkg::ST_F) |-> (s.cnt + 1 == s.cfg.f))
      else $error("hold length wrong");
   access_len_a: assert property (
      $rose(s.phase == ebps_pkg::ST_E) |-> (s.cnt == s.cfg.e) && (s.bus.cmdRd || s.bus.cmdWr))
      else $error("access phase length or command wrong");
   edge_gap_a: assert property (
      (s.phase != ebps_pkg::ST_IDLE) && !tick |=> (SYS_OK || (TU_DIV >= ebps_pkg::MIN_EDGE_CYC))
         && $stable({s.bus.csSel, s.bus.ale, s.bus.cmdRd, s.bus.cmdWr, s.bus.dataOe}))
      else $error("bus edges closer than allowed");
   clk_sel_a: assert property (
      regWr && regAddr == ebps_pkg::OFS_CTRL |=> busOut.refClkSel == $past(wrCtrl.clkSel))
      else $error("reference clock select not taken");
   rdy_end_a: assert property (
      s.phase == ebps_pkg::ST_RDY && tick && rdyAct && s.waitSeen |=> s.phase != ebps_pkg::ST_RDY)
      else $error("active ready did not end cycle");
   rdy_wait_a: assert property (
      s.phase == ebps_pkg::ST_RDY && tick && (rdyLvl != s.cfg.rdyPol) |=> s.phase == ebps_pkg::ST_RDY)
      else $error("inactive ready did not wait");
   async_wait_a: assert property (
      $rose(s.phase == ebps_pkg::ST_RDY) && s.cfg.rdyAsync |=> s.phase == ebps_pkg::ST_RDY)
      else $error("async ready skipped its waitstate");
   tick_gap_a: assert property (
      tick ##1 (s.phase != ebps_pkg::ST_IDLE) |-> (s.pre == '0))
      else $error("time unit prescaler not restarted");

   ready_wait_c: cover property (s.phase == ebps_pkg::ST_RDY && tick && !rdyAct);
   window_chg_c: cover property ($rose(s.phase == ebps_pkg::ST_AB) && s.extOn);
   write_done_c: cover property ($rose(s.done) && s.wr);
endmodule
`default_nettype wire

// >>> inc/ebps_pkg.sv
// Operation
// - five bus phases run in order, zero-length ones skipped
// - phase lengths per chip select; command 0..3
// - address setup 1..2, plus 0..3 on window change
// - write setup or turnaround lasts 0 or 1
// - hold phase lasts 0 to 3 units
// - access 1..32 units, optionally ready-ended
// - clock at most 80 MHz or 12.5 ns edges
// - reference clock is system clock routed out
// - ready inactive waits, ready active ends cycle
// - async ready synchronised, at least one waitstate
// - ready polarity chosen by configuration
package ebps_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h1;
   localparam logic [3:0] OFS_TCFG = 4'h4;  // one slot per chip select
   localparam int         N_CS     = 4;
   localparam int         CS_W     = 2;
   localparam int         DATA_W   = 16;
   localparam int         CNT_W    = 5;
   localparam int         PRE_W    = 8;
   localparam int         WAIT_W   = 8;
   // timing figures
   localparam int         CLK_PERIOD_PS = 50000;  // 20 MHz system clock
   localparam int         SYS_MHZ       = 20;
   localparam int         MAX_SYS_MHZ   = 80;
   localparam int         MIN_EDGE_PS   = 12500;  // 12.5 ns between edges
   localparam int         MIN_EDGE_CYC  = (MIN_EDGE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [PRE_W-1:0] TU_DIV_DEF = 8'h01;  // clocks per time unit

   // cycle phases; code order is the bus order
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_AB   = 3'h1,
      ST_C    = 3'h2,
      ST_D    = 3'h3,
      ST_E    = 3'h4,
      ST_RDY  = 3'h5,
      ST_F    = 3'h6
   } ebps_phase_t;

   // per chip select timing word, lengths stored minus one where nonzero
   typedef struct packed {
      logic       rdyAsync;  // ready taken from the pin, skipping the link clock stage
      logic       rdyPol;    // 1: ready active high
      logic       rdyEn;     // access end governed by ready
      logic [1:0] f;         // hold units
      logic [4:0] e;         // access units minus one
      logic       d;         // write setup / turnaround units
      logic [1:0] c;         // command delay units
      logic [1:0] abExt;     // extra setup on window change
      logic       ab;        // setup units minus one
   } ebps_tcfg_t;

   typedef struct packed {
      logic            clkSel;  // route system clock to reference pin
      logic [CS_W-1:0] cs;
      logic            wr;
      logic            start;
   } ebps_ctrl_t;

   typedef struct packed {
      logic              done;
      logic              busy;
      ebps_phase_t       phase;
      logic [WAIT_W-1:0] waitCnt;
   } ebps_stat_t;

   // bus strobes, all active high at this boundary
   typedef struct packed {
      logic [N_CS-1:0] csSel;
      logic            ale;
      logic            cmdRd;
      logic            cmdWr;
      logic            dataOe;
      logic            busy;
      logic            refClkSel;
   } ebps_bus_t;

   // link side state
   typedef struct packed {
      logic rstMeta;
      logic rstSync;
      logic rdyMeta;
      logic rdyLvl;
   } ebps_lnk_t;
endpackage

// >>> verilog/ebps_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two flop level synchroniser into the system clock domain
module ebps_sync2 #(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [1:0][W-1:0] s;    // [0] meta, [1] settled
   logic [1:0][W-1:0] sNxt;

   // meta stage feeds only the settled stage
   always_comb begin
      sNxt[0] = d;
      sNxt[1] = s[0];
   end

   // frozen while ce is low
   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else if (ce) begin
         s <= sNxt;
      end
   end

   assign q = s[1];
endmodule
`default_nettype wire

// >>> verilog/ebps_link_ready.sv
`timescale 1ns/1ps
`default_nettype none
// samples the ready pin on the link clock
module ebps_link_ready (
   input  wire logic linkClk,
   input  wire logic reset,
   input  wire logic readyPin,
   output logic      linkRdy
);
   ebps_pkg::ebps_lnk_t s;
   ebps_pkg::ebps_lnk_t sNxt;

   // reset arrives from the system domain, so it is resynchronised
   always_comb begin
      sNxt         = s;
      sNxt.rstMeta = reset;
      sNxt.rstSync = s.rstMeta;
      sNxt.rdyMeta = readyPin;
      sNxt.rdyLvl  = s.rdyMeta;
   end

   // link clock may stop between frames; the level simply holds
   always_ff @(posedge linkClk) begin
      if (s.rstSync) begin
         s.rdyMeta <= 1'b0;
         s.rdyLvl  <= 1'b0;
         s.rstMeta <= sNxt.rstMeta;
         s.rstSync <= sNxt.rstSync;
      end else begin
         s <= sNxt;
      end
   end

   assign linkRdy = s.rdyLvl;
endmodule
`default_nettype wire

// >>> tb/ebps_ready_dev.sv
`timescale 1ns/1ps
`default_nettype none
// external device that ends the access phase with a ready level
module ebps_ready_dev (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       cmd,    // read or write command on the bus
   input  wire logic       pol,    // 1: ready active high
   input  wire logic [3:0] delay,  // command cycles before ready
   output logic            readyPin
);
   logic [3:0] cnt;  // command cycles so far

   initial begin
      readyPin = 1'b0;
      cnt      = 4'h0;
   end

   // ready stays active until the command trails, so it outlasts one reference period
   always @(posedge clk) begin
      if (reset || !cmd) begin
         cnt      <= 4'h0;
         readyPin <= ~pol;  // inactive level between commands
      end else begin
         if (cnt != 4'hf) begin
            cnt <= cnt + 4'h1;
         end
         readyPin <= (cnt >= delay) ? pol : ~pol;  // slow or prompt answer
      end
   end
endmodule
`default_nettype wire

// >>> tb/ebps_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the bus phase sequencer
module ebps_sequencer_tb;
   localparam int TUD = 2;  // clocks per time unit, above 1 so unit scaling shows

   logic                        clk;
   logic                        linkClk;
   logic                        reset;
   logic                        ce;
   logic [3:0]                  regAddr;
   logic [ebps_pkg::DATA_W-1:0] regWdata;
   logic                        regWr;
   logic                        regRd;
   logic [ebps_pkg::DATA_W-1:0] regRdata;
   logic                        readyPin;
   ebps_pkg::ebps_bus_t         busOut;
   logic                        mPol;    // model ready polarity
   logic [3:0]                  mDelay;  // model ready delay
   int                          fail_count;
   int                          checks;
   int                          cycles;  // timeout counter
   int                          nAle, nC, nD, nCmd, nF;  // phase cycle counts of last run

   // 50 ns system clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // 12 ns link clock, phase unrelated
   initial begin
      linkClk = 1'b0;
      #7;
      forever #6 linkClk = ~linkClk;
   end

   ebps_sequencer #(.TU_DIV(8'(TUD))) DUT (.clk(clk), .reset(reset), .ce(ce), .linkClk(linkClk),
      .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .readyPin(readyPin), .busOut(busOut));
   ebps_ready_dev partner (.clk(clk), .reset(reset), .cmd(busOut.cmdRd | busOut.cmdWr),
      .pol(mPol), .delay(mDelay), .readyPin(readyPin));

   task automatic complete_run;
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // one-cycle read strobe, data taken in the following cycle only
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask

   // launch one bus cycle and count its phases from the strobes
   task automatic run(input logic [1:0] cs, input logic [15:0] cfg, input logic w, input logic sel);
      logic seenCmd;
      seenCmd = 1'b0;
      nAle = 0;
      nC = 0;
      nD = 0;
      nCmd = 0;
      nF = 0;
      wr(ebps_pkg::OFS_TCFG + {2'h0, cs}, cfg);
      wr(ebps_pkg::OFS_CTRL, {11'h0, sel, cs, w, 1'b1});
      #1;
      chk("busy on start", 16'h1, {15'h0, busOut.busy});
      for (int i = 0; i < 400 && busOut.busy === 1'b1; i++) begin
         chk("chip select", {12'h0, 4'h1 << cs}, {12'h0, busOut.csSel});
         if (busOut.ale) begin
            nAle++;
            chk("setup after command", 16'h0, {15'h0, seenCmd});
         end else if (busOut.cmdRd | busOut.cmdWr) begin
            nCmd++;
            seenCmd = 1'b1;
            chk("command kind", {15'h0, w}, {15'h0, busOut.cmdWr});
            chk("data drive in access", {15'h0, w}, {15'h0, busOut.dataOe});
         end else if (seenCmd) begin
            nF++;
         end else if (busOut.dataOe) begin
            nD++;
         end else begin
            nC++;
         end
         @(posedge clk);
         #1;
      end
      chk("select idle", 16'h0, {11'h0, busOut.busy, busOut.csSel});
      chk("reference clock select", {15'h0, sel}, {15'h0, busOut.refClkSel});
   endtask

   // reset values, readback, unmapped place
   task automatic t_regs;
      logic [15:0] v;
      rd(ebps_pkg::OFS_TCFG + 4'h2, v);
      chk("timing reset", 16'h0, v);
      wr(ebps_pkg::OFS_TCFG + 4'h2, 16'ha5c3);
      rd(ebps_pkg::OFS_TCFG + 4'h2, v);
      chk("timing readback", 16'ha5c3, v);
      wr(4'h3, 16'hffff);
      rd(4'h3, v);
      chk("unmapped read", 16'h0, v);
      rd(ebps_pkg::OFS_STAT, v);
      chk("status reset", 16'h0, v);
      // a write while the clock enable is low must not land
      @(posedge clk);
      ce <= 1'b0;
      wr(ebps_pkg::OFS_TCFG + 4'h1, 16'h1234);
      ce <= 1'b1;
      rd(ebps_pkg::OFS_TCFG + 4'h1, v);
      chk("frozen write", 16'h0, v);
   endtask

   // every command, write setup and hold length, access at both ends
   task automatic t_phases;
      logic [1:0] c;
      logic [4:0] e;
      logic       d;
      logic       a;
      logic       w;
      for (int k = 0; k < 8; k++) begin
         c = k[1:0];
         d = k[0];
         a = k[2];
         w = k[1] ^ k[2];
         e = (k == 7) ? 5'h1f : 5'(k);
         run(2'h0, {3'h0, ~c, e, d, c, 2'h0, a}, w, k[2]);
         chk("setup length", 16'((a + 1) * TUD), 16'(nAle));
         chk("command length", 16'((c + (w ? 0 : d)) * TUD), 16'(nC));
         chk("write setup length", 16'((w ? d : 0) * TUD), 16'(nD));
         chk("access length", 16'((e + 1) * TUD), 16'(nCmd));
         chk("hold length", 16'((3 - c) * TUD), 16'(nF));
      end
   endtask

   // extra setup only when the chip select changes
   task automatic t_window;
      run(2'h1, 16'h0007, 1'b0, 1'b0);
      chk("setup on change", 16'(5 * TUD), 16'(nAle));
      run(2'h1, 16'h0007, 1'b1, 1'b0);
      chk("setup same window", 16'(2 * TUD), 16'(nAle));
      run(2'h2, 16'h0007, 1'b0, 1'b0);
      chk("setup on second change", 16'(5 * TUD), 16'(nAle));
   endtask

   // ready ended access, both polarities, both sampling modes
   task automatic t_ready;
      logic [15:0] v;
      int          lo;
      for (int k = 0; k < 4; k++) begin
         mPol   <= k[0];
         mDelay <= k[1] ? 4'h0 : 4'h3;
         lo = k[1] ? 2 * TUD : 4;
         // clear done first so the flag check below means something
         wr(ebps_pkg::OFS_STAT, 16'h1000);
         rd(ebps_pkg::OFS_STAT, v);
         chk("done cleared", 16'h0, {15'h0, v[12]});
         run(2'h3, {k[1], k[0], 1'b1, 13'h0}, k[0], 1'b1);
         chk("ready access floor", 16'h1, {15'h0, nCmd >= lo});
         chk("ready access ceiling", 16'h1, {15'h0, nCmd <= 24});
         rd(ebps_pkg::OFS_STAT, v);
         chk("done flag", 16'h1, {15'h0, v[12]});
         chk("waitstates counted", 16'h1, {15'h0, v[7:0] != 8'h0});
      end
   endtask

   // main sequence
   initial begin
      fail_count = 0;
      checks = 0;
      cycles = 0;
      reset = 1'b1;
      ce = 1'b1;
      regAddr = 4'h0;
      regWdata = 16'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      mPol = 1'b1;
      mDelay = 4'h0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_phases();
      t_window();
      t_ready();
      complete_run();
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         complete_run();
      end
   end
endmodule
`default_nettype wire
